//--- logic/flash_protection_controller.sv
`timescale 1ns/1ps
// Behaviour
// - Single bank of 256-byte pages; 1024, 512 or 256 pages per build.
// - 128-byte write buffer filled over 32-bit words before page program.
// - Software picks 128-bit or 64-bit array fetch width.
// - A command returns a descriptor of page, bank and lock geometry.
// - Lock regions of 64 pages, one lock bit each, up to 16.
// - Program or erase into a locked region aborts untouched and flags.
// - Set-lock and clear-lock commands protect and unprotect a region.
// - A qualified erase strap clears every lock bit.
// - Security bit set refuses debug probe and parallel port accesses.
// - Security set only by command; cleared by strap plus full erase.
// - Calibration bits read-only and untouched by the strap.
// - 128-bit unique identifier read-only and untouched by the strap.
// - Parallel port transfers are fully handshaked.
// - Parallel port takes read, program, erase, full erase, lock, unlock, protect.
// - Strap debounced on slow tick; erase only after 220 ms held.
// - Erased words read all ones.
// - Strap also clears general bit 1, booting from ROM.
module flash_protection_controller #(
    parameter int PAGES = flash_ctrl_pkg::PAGES_MAX,
    parameter int DIV_CYCLES = flash_ctrl_pkg::SLOW_DIV,
    parameter int STRAP_TICKS = flash_ctrl_pkg::STRAP_TICKS,
    // Identity values below are arbitrary
    parameter logic [31:0] FLASH_ID = 32'h0000_1234,
    parameter logic [127:0] UNIQUE_ID = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff,
    parameter logic [7:0] CALIB_BITS = 8'h5c
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps
    input wire logic erase_strap,
    input wire logic test_mode_pin,
    input wire logic prog_select_a,
    input wire logic prog_select_b,
    // Parallel programming port
    input wire logic pp_strobe,
    input wire logic [31:0] pp_data_in,
    output logic [31:0] pp_data_out,
    output logic pp_data_oe,
    output logic pp_ack,
    // Status
    output logic flash_ready,
    output logic lock_abort_irq,
    output logic debug_probe_path_enable,
    output logic boot_from_flash
);
    import flash_ctrl_pkg::*;
    localparam int WORDS = PAGES * PAGE_WORDS;
    localparam int FA = $clog2(WORDS);
    localparam int PA = $clog2(PAGES);
    localparam int RB = $clog2(REGION_PAGES);
    localparam int LW = PA - RB;
    localparam int NLOCK = PAGES / REGION_PAGES;
    localparam int WB = $clog2(WBUF_WORDS);
    localparam int DW = $clog2(DIV_CYCLES);
    localparam int SW = $clog2(STRAP_TICKS + 1);

    // ----------------------------------------
    // Pin filtering and slow tick
    // ----------------------------------------
    logic [4:0] pins;
    logic strap_s, test_s, sel_a_s, sel_b_s, strobe_s;
    logic [DW-1:0] div_cnt;
    logic slow_tick;
    logic [SW-1:0] strap_cnt;

    pin_filter #(.W(5)) u_pins (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin_raw({erase_strap, test_mode_pin, prog_select_a, prog_select_b, pp_strobe}),
        .pin_clean(pins)
    );
    assign {strap_s, test_s, sel_a_s, sel_b_s, strobe_s} = pins;
    wire pp_mode = test_s & ~sel_a_s & ~sel_b_s;
    wire strap_hit = strap_s & slow_tick & (strap_cnt == SW'(STRAP_TICKS - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            slow_tick <= 1'b0;
        end else begin
            slow_tick <= (div_cnt == DW'(DIV_CYCLES - 1));
            div_cnt <= (div_cnt == DW'(DIV_CYCLES - 1)) ? '0 : div_cnt + 1'b1;
        end
    end

    // Short pulses restart the count, so they never reach the erase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= '0;
        end else if (!strap_s) begin
            strap_cnt <= '0;
        end else if (slow_tick && strap_cnt != SW'(STRAP_TICKS)) begin
            strap_cnt <= strap_cnt + 1'b1;
        end
    end

    // ----------------------------------------
    // Command launch and decode
    // ----------------------------------------
    eng_e eng;
    pp_e pp_st;
    logic [FA-1:0] eaddr;
    logic [FA:0] ecnt;
    logic [NLOCK-1:0] locks;
    logic [1:0] nv;
    logic cmd_err, lock_err, strap_pend, strap_run;
    logic [2:0] desc_idx;
    logic [7:0] pp_cmd;
    logic [15:0] pp_arg;
    logic [WB-1:0] pp_wcnt;
    logic [31:0] flash_mem [WORDS];
    logic [31:0] wbuf [WBUF_WORDS];

    wire idle = (eng == ENG_IDLE);
    wire commit = psel & penable & pready;
    wire sel_cmd = (paddr == OFS_CMD);
    wire key_ok = (pwdata[31:CMD_KEY_LSB] == CMD_KEY);
    wire apb_cmd = commit & pwrite & sel_cmd & key_ok & ~pp_mode;
    wire apb_go = apb_cmd & idle & ~strap_pend;
    wire beat = pp_mode & strobe_s & ~pp_ack & ~nv[0];
    wire beat_ok = beat & idle & ~strap_pend;
    wire pp_last = (pp_wcnt == WB'(WBUF_WORDS - 1));
    wire pp_arg_go = (pp_st == PP_ARG)
        & (pp_cmd != CMD_WP) & (pp_cmd != CMD_READ);
    wire pp_go = beat_ok & (pp_arg_go | (pp_st == PP_DATA) & pp_last);
    wire strap_go = strap_pend & idle;
    wire go = strap_go | pp_go | apb_go;
    wire [7:0] l_cmd = strap_go ? CMD_EA : pp_go ? pp_cmd : pwdata[CMD_ARG_LSB-1:0];
    wire [15:0] l_arg = strap_go ? 16'h0000 : !pp_go ? pwdata[CMD_KEY_LSB-1:CMD_ARG_LSB]
        : (pp_st == PP_ARG) ? pp_data_in[15:0] : pp_arg;
    wire [PA-1:0] l_page = l_arg[PA-1:0];
    wire is_wp = (l_cmd == CMD_WP);
    wire is_ep = (l_cmd == CMD_EP);
    wire is_ea = (l_cmd == CMD_EA);
    wire is_slb = (l_cmd == CMD_SLB);
    wire is_clb = (l_cmd == CMD_CLB);
    wire is_sgpb = (l_cmd == CMD_SGPB);
    wire is_cgpb = (l_cmd == CMD_CGPB);
    wire is_getd = (l_cmd == CMD_GETD);
    wire known = is_wp | is_ep | is_ea | is_slb | is_clb | is_sgpb | is_cgpb | is_getd;
    wire bad_arg = ((is_slb | is_clb) & (|l_arg[15:LW])) | ((is_sgpb | is_cgpb) & (|l_arg[15:1]))
        | (is_cgpb & ~l_arg[0]);
    wire bad_cmd = go & (~known | bad_arg);
    wire lock_abort = go & (((is_wp | is_ep) & locks[l_page[PA-1:RB]]) | (is_ea & (|locks)));
    wire erase_end = (eng == ENG_ERASE) & (ecnt == (FA + 1)'(1));

    // ----------------------------------------
    // Program and erase engine
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eng <= ENG_IDLE;
            eaddr <= '0;
            ecnt <= '0;
        end else begin
            case (eng)
                ENG_IDLE: begin
                    if (go && !lock_abort && is_wp) begin
                        eng <= ENG_PROG;
                        eaddr <= {l_page, l_arg[ARG_HALF_BIT], WB'(0)};
                        ecnt <= (FA + 1)'(WBUF_WORDS);
                    end else if (go && !lock_abort && is_ep) begin
                        eng <= ENG_ERASE;
                        eaddr <= {l_page, RB'(0)};
                        ecnt <= (FA + 1)'(PAGE_WORDS);
                    end else if (go && !lock_abort && is_ea) begin
                        eng <= ENG_ERASE;
                        eaddr <= '0;
                        ecnt <= (FA + 1)'(WORDS);
                    end
                end
                default: begin
                    eaddr <= eaddr + 1'b1;
                    ecnt <= ecnt - 1'b1;
                    if (ecnt == (FA + 1)'(1)) begin
                        eng <= ENG_IDLE;
                    end
                end
            endcase
        end
    end

    // Programming can only clear bits, as in a real cell
    always_ff @(posedge mclk) begin
        if (eng == ENG_PROG) begin
            flash_mem[eaddr] <= flash_mem[eaddr] & wbuf[eaddr[WB-1:0]];
        end else if (eng == ENG_ERASE) begin
            flash_mem[eaddr] <= '1;
        end
    end

    always_ff @(posedge mclk) begin
        if (commit && pwrite && paddr >= OFS_WBUF) begin
            wbuf[paddr[WB+1:2]] <= pwdata;
        end else if (beat_ok && pp_st == PP_DATA) begin
            wbuf[pp_wcnt] <= pp_data_in;
        end
    end

    // ----------------------------------------
    // Locks, general bits and flags
    // ----------------------------------------
    wire stat_rd = commit & ~pwrite & (paddr == OFS_STATUS);
    wire res_rd = commit & ~pwrite & (paddr == OFS_RESULT);
    wire gp_ok = go & ~bad_arg;

    // Nonvolatile state restarts at its reset constant; a limitation of this model
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            locks <= '0;
            nv <= 2'b00;
            cmd_err <= 1'b0;
            lock_err <= 1'b0;
            strap_pend <= 1'b0;
            strap_run <= 1'b0;
            desc_idx <= 3'h7;
        end else begin
            if (strap_hit) begin
                locks <= '0;
            end else if (gp_ok && is_slb) begin
                locks[l_arg[LW-1:0]] <= 1'b1;
            end else if (gp_ok && is_clb) begin
                locks[l_arg[LW-1:0]] <= 1'b0;
            end
            if (strap_hit) begin
                nv[1] <= 1'b0;
            end else if (gp_ok && is_sgpb) begin
                nv[l_arg[0]] <= 1'b1;
            end else if (gp_ok && is_cgpb) begin
                nv[1] <= 1'b0;
            end
            if (erase_end && strap_run) begin
                nv[0] <= 1'b0;
            end
            strap_pend <= strap_hit | (strap_pend & ~strap_go);
            strap_run <= strap_go | (strap_run & ~erase_end);
            cmd_err <= bad_cmd | (apb_cmd & ~apb_go) | (cmd_err & ~stat_rd);
            lock_err <= lock_abort | (lock_err & ~stat_rd);
            if (go && is_getd) begin
                desc_idx <= 3'h0;
            end else if (res_rd && desc_idx != 3'h7) begin
                desc_idx <= desc_idx + 1'b1;
            end
        end
    end

    function automatic logic [31:0] desc_word(input logic [2:0] i);
        case (i)
            3'h0: desc_word = FLASH_ID;
            3'h1: desc_word = 32'(WORDS * 4);
            3'h2: desc_word = 32'(PAGE_BYTES);
            3'h3: desc_word = 32'(PLANES);
            3'h4: desc_word = 32'(WORDS * 4 / PLANES);
            3'h5: desc_word = 32'(NLOCK);
            3'h6: desc_word = 32'(REGION_PAGES * PAGE_BYTES);
            default: desc_word = 32'h0000_0000;
        endcase
    endfunction

    // ----------------------------------------
    // APB slave and read window
    // ----------------------------------------
    logic [MODE_WS_MSB:0] ws;
    logic narrow;
    logic [MODE_WS_MSB:0] wcnt;
    logic [FA-1:0] rd_addr;
    logic [FA-1:0] tag;
    logic tag_ok;

    wire acc = psel & penable & ~pready;
    wire sel_rdata = (paddr == OFS_RDATA);
    wire sel_uid = (paddr >= OFS_UID0) & (paddr <= OFS_UID3);
    wire mapped = (paddr[1:0] == 2'b00) & ((paddr <= OFS_UID3) | (paddr >= OFS_WBUF));
    // A 64-bit fetch holds two words, a 128-bit fetch four
    wire rd_hit = tag_ok & (rd_addr[FA-1:2] == tag[FA-1:2])
        & (narrow ? rd_addr[1] == tag[1] : 1'b1);
    wire rd_miss_acc = acc & sel_rdata & ~pwrite;
    wire stall = rd_miss_acc & (~idle | (~rd_hit & wcnt != ws));
    wire answer = acc & ~stall;
    wire [127:0] uid_sh = UNIQUE_ID >> {paddr[3:2], 5'h00};
    wire [31:0] rd_mux = (paddr == OFS_MODE) ? ((32'(narrow) << MODE_NARROW_BIT) | 32'(ws))
        : (paddr == OFS_STATUS) ? {27'h0, pp_mode, nv[0], lock_err, cmd_err, idle}
        : (paddr == OFS_RESULT) ? desc_word(desc_idx)
        : (paddr == OFS_LOCKS) ? 32'(locks)
        : (paddr == OFS_NVBITS) ? ((32'(CALIB_BITS) << NV_CALIB_LSB) | 32'(nv))
        : (paddr == OFS_RADDR) ? 32'({rd_addr, 2'b00})
        : sel_rdata ? flash_mem[rd_addr]
        : sel_uid ? uid_sh[31:0] : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
            wcnt <= '0;
        end else begin
            pready <= answer;
            if (answer) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~mapped;
            end
            if (answer) begin
                wcnt <= '0;
            end else if (rd_miss_acc && idle && !rd_hit) begin
                wcnt <= wcnt + 1'b1;
            end
        end
    end

    // A new fetch width or any array write drops the line buffer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ws <= MODE_WS_RST;
            narrow <= 1'b0;
            rd_addr <= '0;
            tag <= '0;
            tag_ok <= 1'b0;
        end else begin
            if (commit && pwrite && paddr == OFS_MODE) begin
                ws <= pwdata[MODE_WS_MSB:0];
                narrow <= pwdata[MODE_NARROW_BIT];
            end
            if (commit && pwrite && paddr == OFS_RADDR) begin
                rd_addr <= pwdata[FA+1:2];
            end else if (commit && !pwrite && sel_rdata) begin
                rd_addr <= rd_addr + 1'b1;
            end
            if (go || (commit && pwrite && paddr == OFS_MODE)) begin
                tag_ok <= 1'b0;
            end else if (answer && rd_miss_acc) begin
                tag <= rd_addr;
                tag_ok <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Parallel programming port
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pp_st <= PP_CMD;
            pp_cmd <= '0;
            pp_arg <= '0;
            pp_wcnt <= '0;
            pp_ack <= 1'b0;
            pp_data_out <= '0;
            pp_data_oe <= 1'b0;
        end else if (!pp_mode) begin
            pp_st <= PP_CMD;
            pp_ack <= 1'b0;
            pp_data_oe <= 1'b0;
        end else if (pp_ack && !strobe_s) begin
            pp_ack <= 1'b0;
            pp_data_oe <= 1'b0;
        end else if (beat_ok) begin
            pp_ack <= 1'b1;
            case (pp_st)
                PP_CMD: begin
                    pp_cmd <= pp_data_in[7:0];
                    pp_st <= PP_ARG;
                end
                PP_ARG: begin
                    pp_arg <= pp_data_in[15:0];
                    pp_wcnt <= '0;
                    pp_st <= (pp_cmd == CMD_WP) ? PP_DATA : PP_CMD;
                    if (pp_cmd == CMD_READ) begin
                        pp_data_out <= flash_mem[pp_data_in[FA-1:0]];
                        pp_data_oe <= 1'b1;
                    end
                end
                default: begin
                    pp_wcnt <= pp_wcnt + 1'b1;
                    if (pp_last) begin
                        pp_st <= PP_CMD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_ready <= 1'b0;
            lock_abort_irq <= 1'b0;
            debug_probe_path_enable <= 1'b0;
            boot_from_flash <= 1'b0;
        end else begin
            flash_ready <= idle;
            lock_abort_irq <= lock_err;
            debug_probe_path_enable <= ~nv[0];
            boot_from_flash <= nv[1];
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_lock_abort_idle: assert property (lock_abort |=> idle && lock_err)
        else $error("locked command did not abort");
    a_key_ignored: assert property (commit && pwrite && sel_cmd && !key_ok && idle && !strap_pend
        && !pp_go |=> idle)
        else $error("command without key started");
    a_erase_busy: assert property (go && is_ep && !lock_abort |=> (!idle)[*8])
        else $error("page erase ended too early");
    a_erase_ones: assert property (eng == ENG_ERASE
        |=> flash_mem[$past(eaddr)] == 32'hffff_ffff)
        else $error("erased word not all ones");
    a_strap_locks: assert property (strap_hit |=> locks == '0 && !nv[1])
        else $error("strap left locks or boot bit");
    a_strap_boot: assert property (strap_hit |=> ##2 !boot_from_flash)
        else $error("boot bit not cleared by strap");
    a_secure_refuse: assert property (nv[0] && pp_mode && !pp_ack |=> !pp_ack)
        else $error("secured part answered parallel port");
    a_secure_clear: assert property ($fell(nv[0]) |-> $past(strap_run) && $past(erase_end))
        else $error("security cleared outside strap erase");
    a_calib_fixed: assert property (commit && !pwrite && paddr == OFS_NVBITS
        |-> prdata[NV_CALIB_LSB+7:NV_CALIB_LSB] == CALIB_BITS)
        else $error("calibration bits changed");
    a_ws_wait: assert property (rd_miss_acc && idle && !rd_hit && wcnt != ws |=> !pready)
        else $error("wait states skipped");
    a_lock_set: assert property (go && is_slb && !bad_arg |=> locks[$past(l_arg[LW-1:0])])
        else $error("lock bit not set");
    a_strap_short: assert property ($rose(strap_s) |-> (!strap_hit)[*8])
        else $error("strap erased without debounce");
    a_desc_start: assert property (go && is_getd |=> desc_idx == 3'h0)
        else $error("descriptor did not restart");

    c_page_prog: cover property (go && is_wp && !lock_abort ##1 eng == ENG_PROG);
    c_lock_abort: cover property (lock_abort);
    c_pp_launch: cover property (pp_go);
    c_strap_erase: cover property (strap_run && erase_end);
endmodule

//--- logic/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    // ----------------------------------------
    // Clock and strap timing
    // ----------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int SLOW_HZ = 32_768;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;
    localparam int STRAP_MS = 220;
    localparam int STRAP_TICKS = (STRAP_MS * SLOW_HZ + 999) / 1000;
    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int PAGES_MAX = 1024;
    localparam int PAGE_BYTES = 256;
    localparam int PAGE_WORDS = PAGE_BYTES / 4;
    localparam int WBUF_BYTES = 128;
    localparam int WBUF_WORDS = WBUF_BYTES / 4;
    localparam int REGION_PAGES = 64;
    localparam int PLANES = 1;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0c;
    localparam logic [7:0] OFS_LOCKS = 8'h10;
    localparam logic [7:0] OFS_NVBITS = 8'h14;
    localparam logic [7:0] OFS_RADDR = 8'h18;
    localparam logic [7:0] OFS_RDATA = 8'h1c;
    localparam logic [7:0] OFS_UID0 = 8'h20;
    localparam logic [7:0] OFS_UID3 = 8'h2c;
    localparam logic [7:0] OFS_WBUF = 8'h80;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int MODE_WS_MSB = 3;
    localparam int MODE_NARROW_BIT = 8;
    localparam int CMD_KEY_LSB = 24;
    localparam int CMD_ARG_LSB = 8;
    localparam int ARG_HALF_BIT = 15;
    localparam int NV_CALIB_LSB = 8;
    localparam logic [3:0] MODE_WS_RST = 4'h2;
    localparam logic [7:0] CMD_KEY = 8'h5a;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_GETD = 8'h00;
    localparam logic [7:0] CMD_WP = 8'h01;
    localparam logic [7:0] CMD_EP = 8'h02;
    localparam logic [7:0] CMD_EA = 8'h05;
    localparam logic [7:0] CMD_SLB = 8'h08;
    localparam logic [7:0] CMD_CLB = 8'h09;
    localparam logic [7:0] CMD_SGPB = 8'h0b;
    localparam logic [7:0] CMD_CGPB = 8'h0c;
    localparam logic [7:0] CMD_READ = 8'h0f;
    // ----------------------------------------
    // State types
    // ----------------------------------------
    typedef enum {ENG_IDLE, ENG_PROG, ENG_ERASE} eng_e;
    typedef enum {PP_CMD, PP_ARG, PP_DATA} pp_e;
endpackage

//--- logic/pin_filter.sv
`timescale 1ns/1ps
module pin_filter #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Raw pins
    input wire logic [W-1:0] pin_raw,
    // Filtered levels
    output logic [W-1:0] pin_clean
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;

    // A bit changes only once the second and third stages agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            pin_clean <= '0;
        end else begin
            ff1 <= pin_raw;
            ff2 <= ff1;
            ff3 <= ff2;
            pin_clean <= (ff2 & ff3) | (pin_clean & (ff2 | ff3));
        end
    end
endmodule

//--- tb/pp_prog.sv
`timescale 1ns/1ps
module pp_prog (
    // Port pins
    input wire logic mclk,
    input wire logic pp_ack,
    input wire logic [31:0] pp_data_out,
    output logic pp_strobe,
    output logic [31:0] pp_data_in
);
    int timeouts = 0;
    initial begin
        pp_strobe = 1'b0;
        pp_data_in = 32'h0;
    end
    // Data held until ack; released bus shows inverse so stale words never look valid
    task automatic beat(input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        pp_strobe <= 1'b1;
        pp_data_in <= d;
        for (n = 0; n < 300 && pp_ack !== 1'b1; n++) @(posedge mclk);
        if (n == 300) timeouts++;
        q = pp_data_out;
        pp_strobe <= 1'b0;
        pp_data_in <= ~d;
        for (n = 0; n < 300 && pp_ack !== 1'b0; n++) @(posedge mclk);
        if (n == 300) timeouts++;
    endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
    import flash_ctrl_pkg::*;
    localparam logic [15:0] CALIB_BITS_EXP = 16'h5c00;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, pd_in, pd_out, q;
    logic pready, pslverr, strap = 0, tst = 0, sel_a = 1, sel_b = 1;
    logic strobe, pd_oe, ack, rdy, irq, dbg_en, boot_fl;
    int fails = 0, samples_checked = 0, n;
    always #20 mclk = ~mclk;
    flash_protection_controller #(.PAGES(256), .DIV_CYCLES(4), .STRAP_TICKS(3)) DUT (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .erase_strap(strap), .test_mode_pin(tst),
        .prog_select_a(sel_a), .prog_select_b(sel_b), .pp_strobe(strobe),
        .pp_data_in(pd_in), .pp_data_out(pd_out), .pp_data_oe(pd_oe), .pp_ack(ack),
        .flash_ready(rdy), .lock_abort_irq(irq), .debug_probe_path_enable(dbg_en),
        .boot_from_flash(boot_fl));
    pp_prog prog (.mclk(mclk), .pp_ack(ack), .pp_data_out(pd_out), .pp_strobe(strobe),
        .pp_data_in(pd_in));
    // ----
    // Bus tasks
    // ----
    task automatic stop_test();
        $display("compared %0d mismatched %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string s, input logic [31:0] seen, input logic [31:0] e);
        samples_checked++;
        if (seen !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 5000; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 5000) begin
            fails++;
            stop_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string s, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(s, q, e);
    endtask
    task automatic cmd(input logic [7:0] k, input logic [15:0] g, input logic [7:0] c);
        apb(1'b1, OFS_CMD, {k, g, c});
        repeat (2) @(posedge mclk);
        for (n = 0; n < 20000 && rdy !== 1'b1; n++) @(posedge mclk);
        if (n == 20000) begin
            fails++;
            stop_test();
        end
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd("status", OFS_STATUS, 32'h1);
        rd("mode", OFS_MODE, 32'(MODE_WS_RST));
        apb(1'b0, 8'h40, 32'h0);
        check("slverr", 32'(err), 32'h1);
        cmd(8'h00, 16'h1, CMD_SLB);
        rd("bad key", OFS_LOCKS, 32'h0);
        cmd(CMD_KEY, 16'h1, CMD_SLB);
        rd("lock set", OFS_LOCKS, 32'h2);
        cmd(CMD_KEY, 16'd64, CMD_WP);
        check("irq", 32'(irq), 32'h1);
        rd("lock err", OFS_STATUS, 32'h5);
        rd("cleared", OFS_STATUS, 32'h1);
        cmd(CMD_KEY, 16'h1, CMD_CLB);
        rd("lock clr", OFS_LOCKS, 32'h0);
        cmd(CMD_KEY, 16'h0, CMD_SLB);
        cmd(CMD_KEY, 16'h1, CMD_SGPB);
        cmd(CMD_KEY, 16'h0, CMD_SGPB);
        check("dbg off", 32'(dbg_en), 32'h0);
        check("boot", 32'(boot_fl), 32'h1);
        strap <= 1'b1;
        repeat (6) @(posedge mclk);
        strap <= 1'b0;
        repeat (8) @(posedge mclk);
        rd("short strap", OFS_LOCKS, 32'h1);
        strap <= 1'b1;
        repeat (40) @(posedge mclk);
        strap <= 1'b0;
        check("boot rom", 32'(boot_fl), 32'h0);
        cmd(CMD_KEY, 16'h0, CMD_GETD);
        rd("busy refused", OFS_STATUS, 32'h3);
        cmd(CMD_KEY, 16'h0, CMD_GETD);
        apb(1'b0, OFS_RESULT, 32'h0);
        rd("flash size", OFS_RESULT, 32'h0001_0000);
        rd("page bytes", OFS_RESULT, 32'h0000_0100);
        rd("planes", OFS_RESULT, 32'h0000_0001);
        rd("bank bytes", OFS_RESULT, 32'h0001_0000);
        rd("lock count", OFS_RESULT, 32'h0000_0004);
        rd("strap locks", OFS_LOCKS, 32'h0);
        check("dbg on", 32'(dbg_en), 32'h1);
        rd("calib", OFS_NVBITS, 32'(CALIB_BITS_EXP));
        rd("uid", OFS_UID0, 32'hccdd_eeff);
        apb(1'b1, OFS_RADDR, 32'h100);
        rd("erased", OFS_RDATA, 32'hffff_ffff);
        apb(1'b1, OFS_WBUF, 32'h1234_5678);
        cmd(CMD_KEY, 16'h2, CMD_WP);
        apb(1'b1, OFS_RADDR, 32'h200);
        rd("programmed", OFS_RDATA, 32'h1234_5678);
        cmd(CMD_KEY, 16'h2, CMD_EP);
        apb(1'b1, OFS_RADDR, 32'h200);
        rd("page erased", OFS_RDATA, 32'hffff_ffff);
        tst <= 1'b1;
        sel_a <= 1'b0;
        sel_b <= 1'b0;
        repeat (8) @(posedge mclk);
        rd("pmode", OFS_STATUS, 32'h11);
        prog.beat(32'(CMD_READ), q);
        prog.beat(32'h40, q);
        check("pp read", q, 32'hffff_ffff);
        check("pp oe", 32'(pd_oe), 32'h0);
        check("pp timeouts", 32'(prog.timeouts), 32'h0);
        stop_test();
    end
endmodule
